// *** rtl/dbgad_front.sv ***
// register-select and identification front end of the two-pin debug port
// assumes: link clock comes from the tool and stops between frames;
// core-side inputs are on mclk, the revision strap is an asynchronous pin
`timescale 1ns/100ps

module dbgad_front
  import dbgad_pkg::*;
#(
  parameter logic [7:0] PART_ID = 8'h5a  // arbitrary value
) (
  // core clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // debug link pins
  input  wire logic       debug_clock_line,
  input  wire logic       debug_data_line_i,
  output logic            debug_data_line_o,
  output logic            debug_data_line_oe,
  // core side status and read data
  input  wire logic       otp_busy,
  input  wire logic [7:0] core_rdata,
  input  wire logic [7:0] revision_strap,
  // core side selection and write strobe
  output logic [7:0]      core_sel,
  output dbgad_dec_s      core_dec,
  output logic            core_wr,
  output logic [7:0]      core_wdata,
  output logic            crc_start,
  output logic [7:0]      crc_page
);

  // link clock domain: these flops only move while the tool clocks the link,
  // so nothing here may wait on time alone; every wait is counted in link edges
  logic        lrst_meta_reg;
  logic        lrst_sync_reg;
  dbgad_link_e state_reg;
  logic [2:0]  bit_reg;
  logic [1:0]  ins_reg;
  logic [7:0]  shift_reg;
  dbgad_wr_s   wr_msg_reg;
  logic        wr_tog_reg;
  logic        snap_meta_reg;
  logic        snap_sync_reg;
  logic        snap_ack_reg;
  dbgad_snap_s snap_copy_reg;
  logic        drive_reg;
  logic        read_ins;

  // core clock domain: free-running mclk, sees link state only through
  // toggle handshakes or words held still by them
  logic        wr_meta_reg;
  logic        wr_sync_reg;
  logic        wr_seen_reg;
  logic        ack_meta_reg;
  logic        ack_sync_reg;
  logic        snap_tog_reg;
  dbgad_snap_s snap_hold_reg;
  dbgad_snap_s snap_next;
  logic [7:0]  rs_meta_reg;
  logic [7:0]  rs_sync_reg;
  logic [7:0]  rev_reg;
  logic        rev_done_reg;
  logic [7:0]  sel_reg;
  dbgad_dec_s  dec_reg;
  dbgad_dec_s  dec_next;
  logic        wr_event;
  logic        wr_core_ok;
  logic        core_wr_reg;
  logic [7:0]  core_wdata_reg;
  logic        crc_start_reg;
  logic [7:0]  crc_page_reg;
  logic [CRC_BYTES-1:0] crc_hit;
  genvar       gi;

  // link reset follows rst_n through two link flops; tool gives idle clocks
  // reset reaches the link only while the tool clocks the link, whatever the line level
  always_ff @(posedge debug_clock_line) begin
    lrst_meta_reg <= rst_n;
    lrst_sync_reg <= lrst_meta_reg;
  end

  // frame engine: start bit, two instruction bits, eight data bits
  // limitation: a frame cut short leaves the engine mid-frame until the next
  // frame's edges or a reset clocked through by the tool; there is no timeout
  always_ff @(posedge debug_clock_line) begin
    if (!lrst_sync_reg) begin
      state_reg <= LK_IDLE;
      bit_reg   <= BIT_FIRST;
      ins_reg   <= INS_DATA_RD;
      shift_reg <= 8'h00;
    end else begin
      case (state_reg)
        LK_IDLE: begin
          if (!debug_data_line_i) begin
            state_reg <= LK_INS0;
          end
        end
        LK_INS0: begin
          ins_reg[0] <= debug_data_line_i;
          state_reg  <= LK_INS1;
        end
        LK_INS1: begin
          ins_reg[1] <= debug_data_line_i;
          bit_reg    <= BIT_FIRST;
          if ({debug_data_line_i, ins_reg[0]} == INS_ADDR_RD) begin
            shift_reg <= snap_copy_reg.status;
            state_reg <= LK_RDATA;
          end else if ({debug_data_line_i, ins_reg[0]} == INS_DATA_RD) begin
            shift_reg <= snap_copy_reg.data;
            state_reg <= LK_RDATA;
          end else begin
            state_reg <= LK_WDATA;
          end
        end
        LK_WDATA: begin
          shift_reg <= {debug_data_line_i, shift_reg[7:1]};
          bit_reg   <= bit_reg + 3'h1;
          if (bit_reg == BIT_LAST) begin
            state_reg <= LK_IDLE;
          end
        end
        LK_RDATA: begin
          shift_reg <= {1'b0, shift_reg[7:1]};
          bit_reg   <= bit_reg + 3'h1;
          if (bit_reg == BIT_LAST) begin
            state_reg <= LK_IDLE;
          end
        end
        default: begin
          state_reg <= LK_IDLE;
        end
      endcase
    end
  end

  // completed write frame: message held stable, then toggle announces it
  always_ff @(posedge debug_clock_line) begin
    if (!lrst_sync_reg) begin
      wr_msg_reg <= '0;
      wr_tog_reg <= 1'b0;
    end else if (state_reg == LK_WDATA && bit_reg == BIT_LAST) begin
      wr_msg_reg.is_addr <= (ins_reg == INS_ADDR_WR);
      wr_msg_reg.value   <= {debug_data_line_i, shift_reg[7:1]};
      wr_tog_reg         <= ~wr_tog_reg;
    end
  end

  // snapshot handshake, link end: copy once toggles differ, then ack
  // the copy is taken only while the core holds its word still, so the
  // sixteen bits never mix two different core cycles
  always_ff @(posedge debug_clock_line) begin
    if (!lrst_sync_reg) begin
      snap_meta_reg <= 1'b0;
      snap_sync_reg <= 1'b0;
      snap_ack_reg  <= 1'b0;
      snap_copy_reg <= '0;
    end else begin
      snap_meta_reg <= snap_tog_reg;
      snap_sync_reg <= snap_meta_reg;
      if (snap_sync_reg != snap_ack_reg) begin
        snap_copy_reg <= snap_hold_reg;  // stable while toggles differ
        snap_ack_reg  <= snap_sync_reg;
      end
    end
  end

  // read instructions are the two whose low instruction bit is clear
  assign read_ins = ({debug_data_line_i, ins_reg[0]} == INS_DATA_RD)
                    || ({debug_data_line_i, ins_reg[0]} == INS_ADDR_RD);

  // pad enable from a flop of its own: a decode of the state word could glitch
  // while several state bits change, and that glitch would reach the shared line
  always_ff @(posedge debug_clock_line) begin
    if (!lrst_sync_reg) begin
      drive_reg <= 1'b0;
    end else if (state_reg == LK_INS1) begin
      drive_reg <= read_ins;
    end else if (state_reg != LK_RDATA || bit_reg == BIT_LAST) begin
      drive_reg <= 1'b0;  // released on the edge that takes the last bit
    end
  end

  // tool must release the data line after the second instruction bit
  assign debug_data_line_o  = shift_reg[0];
  assign debug_data_line_oe = drive_reg;

  // write event crossing into mclk: toggle through two flops, third for edge
  // a toggle, not a pulse: the link clock may stop right after the frame, and
  // a level change survives that where a one-period pulse could be missed
  // by the slower side
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_meta_reg <= 1'b0;
      wr_sync_reg <= 1'b0;
      wr_seen_reg <= 1'b0;
    end else begin
      wr_meta_reg <= wr_tog_reg;
      wr_sync_reg <= wr_meta_reg;
      wr_seen_reg <= wr_sync_reg;
    end
  end

  assign wr_event = wr_sync_reg ^ wr_seen_reg;

  // decode of a candidate select code; crc bytes sit at consecutive codes
  // the message is stable from its toggle until the next write frame ends
  always_comb begin
    dec_next             = '0;
    dec_next.part_id     = (wr_msg_reg.value == SEL_PART_ID);
    dec_next.revision    = (wr_msg_reg.value == SEL_REVISION);
    dec_next.halt        = (wr_msg_reg.value == SEL_HALT);
    dec_next.otp_ctl     = (wr_msg_reg.value == SEL_OTP_CTL);
    dec_next.otp_data    = (wr_msg_reg.value == SEL_OTP_DATA);
    dec_next.otp_stat    = (wr_msg_reg.value == SEL_OTP_STAT);
    dec_next.otp_addr_hi = (wr_msg_reg.value == SEL_OTP_ADDR_HI);
    dec_next.otp_addr_lo = (wr_msg_reg.value == SEL_OTP_ADDR_LO);
    dec_next.crc         = crc_hit;
  end

  // one comparator per crc result byte
  generate
    for (gi = 0; gi < CRC_BYTES; gi = gi + 1) begin : g_crc
      assign crc_hit[gi] = (wr_msg_reg.value == SEL_CRC_BASE + 8'(gi));
    end
  endgenerate

  // select register and its decode, kept until the next address write
  // decode is registered with the code, so data commands see no compare delay
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sel_reg         <= SEL_RESET;
      dec_reg         <= '0;
      dec_reg.part_id <= 1'b1;
    end else if (wr_event && wr_msg_reg.is_addr) begin
      sel_reg <= wr_msg_reg.value;
      dec_reg <= dec_next;
    end
  end

  // read-only targets swallow data writes
  // a dropped write gives the tool no error; it simply reads the same code back
  assign wr_core_ok = wr_event && !wr_msg_reg.is_addr
                      && !dec_reg.part_id && !dec_reg.revision;

  // data write strobe, data and crc launch toward the core
  // the strobe is one mclk wide whatever the link rate
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      core_wr_reg    <= 1'b0;
      core_wdata_reg <= 8'h00;
      crc_start_reg  <= 1'b0;
      crc_page_reg   <= 8'h00;
    end else begin
      core_wr_reg   <= wr_core_ok;
      crc_start_reg <= wr_core_ok && dec_reg.crc[0];
      if (wr_core_ok) begin
        core_wdata_reg <= wr_msg_reg.value;
      end
      if (wr_core_ok && dec_reg.crc[0]) begin
        crc_page_reg <= wr_msg_reg.value;
      end
    end
  end

  // revision strap: synchronised, caught once after reset release
  // limitation: a strap change after that is not seen until the next reset,
  // which keeps the returned code steady for the whole session
  always_ff @(posedge mclk) begin
    rs_meta_reg <= revision_strap;
    rs_sync_reg <= rs_meta_reg;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rev_reg      <= 8'h00;
      rev_done_reg <= 1'b0;
    end else if (!rev_done_reg) begin
      rev_reg      <= rs_sync_reg;
      rev_done_reg <= 1'b1;
    end
  end

  // snapshot content: status byte and data of the selected register
  // status lags otp_busy by up to one handshake round trip
  always_comb begin
    snap_next        = '0;
    snap_next.status = {otp_busy, STATUS_PAD};
    if (dec_reg.part_id) begin
      snap_next.data = PART_ID;
    end else if (dec_reg.revision) begin
      snap_next.data = rev_reg;
    end else begin
      snap_next.data = core_rdata;
    end
  end

  // snapshot handshake, core end: refresh only after link has acked
  // refreshing only then keeps the held word still while the link copies it
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ack_meta_reg  <= 1'b0;
      ack_sync_reg  <= 1'b0;
      snap_tog_reg  <= 1'b0;
      snap_hold_reg <= '0;
    end else begin
      ack_meta_reg <= snap_ack_reg;
      ack_sync_reg <= ack_meta_reg;
      if (ack_sync_reg == snap_tog_reg) begin
        snap_hold_reg <= snap_next;
        snap_tog_reg  <= ~snap_tog_reg;
      end
    end
  end

  // core side outputs
  // all driven straight from flops, no logic after them
  assign core_sel   = sel_reg;
  assign core_dec   = dec_reg;
  assign core_wr    = core_wr_reg;
  assign core_wdata = core_wdata_reg;
  assign crc_start  = crc_start_reg;
  assign crc_page   = crc_page_reg;

endmodule : dbgad_front

// *** rtl/dbgad_pkg.sv ***
// package for the two-pin debug port register-select front end
// assumes: shared by the front end and by bench code only
package dbgad_pkg;

  // selection codes written into the register-select register
  localparam logic [7:0] SEL_PART_ID     = 8'h00;
  localparam logic [7:0] SEL_REVISION    = 8'h01;
  localparam logic [7:0] SEL_HALT        = 8'h02;
  localparam logic [7:0] SEL_OTP_CTL     = 8'hdf;
  localparam logic [7:0] SEL_OTP_DATA    = 8'hbf;
  localparam logic [7:0] SEL_OTP_STAT    = 8'hb7;
  localparam logic [7:0] SEL_OTP_ADDR_HI = 8'haf;
  localparam logic [7:0] SEL_OTP_ADDR_LO = 8'hae;
  localparam logic [7:0] SEL_CRC_BASE    = 8'ha9;
  localparam int         CRC_BYTES       = 4;

  // reset value of the register-select register
  localparam logic [7:0] SEL_RESET       = 8'h00;

  // status byte layout: only the busy flag carries meaning
  localparam int         BUSY_BIT        = 7;
  localparam logic [6:0] STATUS_PAD      = 7'h00;

  // link instruction codes, sent lsb first after the start bit
  localparam logic [1:0] INS_DATA_RD     = 2'h0;
  localparam logic [1:0] INS_DATA_WR     = 2'h1;
  localparam logic [1:0] INS_ADDR_RD     = 2'h2;
  localparam logic [1:0] INS_ADDR_WR     = 2'h3;
  localparam logic [2:0] BIT_FIRST       = 3'h0;
  localparam logic [2:0] BIT_LAST        = 3'h7;

  // write event passed from link side to core side
  typedef struct packed {
    logic       is_addr;
    logic [7:0] value;
  } dbgad_wr_s;

  // read snapshot passed from core side to link side
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] data;
  } dbgad_snap_s;

  // decoded target of data commands
  typedef struct packed {
    logic                 part_id;
    logic                 revision;
    logic                 halt;
    logic                 otp_ctl;
    logic                 otp_data;
    logic                 otp_stat;
    logic                 otp_addr_hi;
    logic                 otp_addr_lo;
    logic [CRC_BYTES-1:0] crc;
  } dbgad_dec_s;

  typedef enum {LK_IDLE, LK_INS0, LK_INS1, LK_WDATA, LK_RDATA} dbgad_link_e;

endpackage : dbgad_pkg

// *** bench/dbgad_front_properties.sv ***
// checker for the debug port front end: decode, write pulses, read drive
// assumes: bound to dbgad_front, sees only its ports
`timescale 1ns/100ps
module dbgad_front_props
  import dbgad_pkg::*;
(
  // clocks and reset
  input logic       mclk,
  input logic       rst_n,
  input logic       debug_clock_line,
  // observed outputs
  input logic       debug_data_line_oe,
  input logic [7:0] core_sel,
  input dbgad_dec_s core_dec,
  input logic       core_wr,
  input logic [7:0] core_wdata,
  input logic       crc_start,
  input logic [7:0] crc_page
);
  // decode must track the held select code in every cycle
  chk_dec_ident: assert property (@(posedge mclk) disable iff (!rst_n)
    {core_dec.part_id, core_dec.revision} == {core_sel == 8'h00, core_sel == 8'h01})
    else $error("identity decode wrong");
  chk_dec_ctrl: assert property (@(posedge mclk) disable iff (!rst_n)
    {core_dec.halt, core_dec.otp_ctl} == {core_sel == 8'h02, core_sel == 8'hdf})
    else $error("control decode wrong");
  chk_dec_otp: assert property (@(posedge mclk) disable iff (!rst_n)
    {core_dec.otp_data, core_dec.otp_stat, core_dec.otp_addr_hi, core_dec.otp_addr_lo} ==
    {core_sel == 8'hbf, core_sel == 8'hb7, core_sel == 8'haf, core_sel == 8'hae})
    else $error("otp decode wrong");
  chk_dec_crc: assert property (@(posedge mclk) disable iff (!rst_n)
    core_dec.crc == {core_sel == 8'hac, core_sel == 8'hab, core_sel == 8'haa,
                     core_sel == 8'ha9})
    else $error("crc decode wrong");
  // read-only targets never see a write strobe
  chk_ro_write: assert property (@(posedge mclk) disable iff (!rst_n)
    core_wr |-> !core_dec.part_id && !core_dec.revision)
    else $error("write to read-only target");
  chk_crc_start: assert property (@(posedge mclk) disable iff (!rst_n)
    crc_start |-> core_wr && core_dec.crc[0] && crc_page == core_wdata)
    else $error("crc start without byte zero write");
  chk_sel_steady: assert property (@(posedge mclk) disable iff (!rst_n)
    core_wr |-> $stable(core_sel) ##1 !core_wr)
    else $error("data write disturbed selection");
  // reset is synchronous, so no disable here
  chk_rst_sel: assert property (@(posedge mclk)
    !rst_n |=> core_sel == SEL_RESET && core_dec.part_id && !core_wr)
    else $error("select not cleared by reset");
  // device drives the shared line for exactly eight link periods
  chk_read_len: assert property (@(posedge debug_clock_line) disable iff (!rst_n)
    $rose(debug_data_line_oe) |-> debug_data_line_oe [*8] ##1 !debug_data_line_oe)
    else $error("read drive length wrong");
  cov_crc: cover property (@(posedge mclk) crc_start);
  cov_wr: cover property (@(posedge mclk) core_wr);
  cov_rd: cover property (@(posedge debug_clock_line) $rose(debug_data_line_oe));
endmodule : dbgad_front_props

// *** bench/dbgad_tool_model.sv ***
// tool-side model of the two-pin debug link: framed clock and data line
// assumes: device drives the line only while its enable is high
`timescale 1ns/100ps
module dbgad_tool (
  // link pins
  output logic debug_clock_line,
  output wire  line,
  // device drive
  input  logic dev_o,
  input  logic dev_oe
);
  logic drv;
  logic val;
  // released line shows the inverse of the tool's own bit, never a copy of it
  assign line = dev_oe ? dev_o : (drv ? val : !val);
  initial begin
    debug_clock_line = 0;
    drv = 1;
    val = 1;
  end
  // clock with the line high so no start bit is seen
  task automatic idle(input int n);
    drv = 1;
    val = 1;
    repeat (n) begin
      #24 debug_clock_line = 1;
      #24 debug_clock_line = 0;
    end
  endtask : idle
  // start bit, two instruction bits, eight data bits, lsb first
  task automatic frame(input logic [1:0] ins, input logic [7:0] wv,
                       output logic [7:0] rv);
    logic [10:0] d;
    d = {wv, ins, 1'b0};
    rv = 8'h00;
    for (int k = 0; k < 11; k++) begin
      drv = ins[0] || k < 3;  // read frames hand the line over
      val = d[k];
      #12 if (!drv) rv[k-3] = line;
      #12 debug_clock_line = 1;
      #24 debug_clock_line = 0;
    end
    drv = 1;
    val = 1;
  endtask : frame
endmodule : dbgad_tool

// *** bench/dbgad_front_tb.sv ***
// self-checking bench for the debug port front end
// assumes: tool model drives the link, bench drives core-side levels
`timescale 1ns/100ps
module dbgad_front_tb
  import dbgad_pkg::*;
;
  localparam logic [7:0] ID  = 8'h3c;  // arbitrary value
  localparam logic [7:0] REV = 8'h2b;  // arbitrary value
  localparam logic [7:0] CODES [13] = '{8'h00, 8'h01, 8'h02, 8'hdf, 8'hbf, 8'hb7,
    8'haf, 8'hae, 8'ha9, 8'haa, 8'hab, 8'hac, 8'h55};
  logic       mclk, rst_n, otp_busy, dl_o, dl_oe, core_wr, crc_start;
  logic [7:0] core_rdata, core_sel, core_wdata, crc_page, rv, strap;
  wire        line, lclk;
  dbgad_dec_s core_dec;
  int         failures = 0, comparisons = 0, wr_cnt = 0, crc_cnt = 0;

  dbgad_front #(.PART_ID(ID)) dbgad_front_i (.mclk(mclk), .rst_n(rst_n),
    .debug_clock_line(lclk), .debug_data_line_i(line), .debug_data_line_o(dl_o),
    .debug_data_line_oe(dl_oe), .otp_busy(otp_busy), .core_rdata(core_rdata),
    .revision_strap(strap), .core_sel(core_sel), .core_dec(core_dec),
    .core_wr(core_wr), .core_wdata(core_wdata), .crc_start(crc_start),
    .crc_page(crc_page));
  dbgad_tool dbgad_tool_i (.debug_clock_line(lclk), .line(line), .dev_o(dl_o),
    .dev_oe(dl_oe));

  initial begin
    mclk = 0;
    forever #25 mclk = !mclk;
  end
  // pulse counters, so a missing or doubled strobe shows
  always @(posedge mclk) begin
    wr_cnt <= wr_cnt + core_wr;
    crc_cnt <= crc_cnt + crc_start;
  end

  task automatic cmp(input string what, input logic [11:0] exp, input logic [11:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask : cmp
  // gap lets the core domain take the write before the next frame
  task automatic wr(input logic [1:0] ins, input logic [7:0] v);
    dbgad_tool_i.frame(ins, v, rv);
    #350;
  endtask : wr
  // idle clocks let the read snapshot catch up first
  task automatic rd(input logic [1:0] ins);
    dbgad_tool_i.idle(8);
    dbgad_tool_i.frame(ins, 8'h00, rv);
  endtask : rd

  task automatic t_reset;
    cmp("sel", SEL_RESET, core_sel);
    rd(INS_DATA_RD);
    cmp("id", ID, rv);
    @(posedge mclk) strap <= ~REV;
    $display("reset test done");
  endtask : t_reset

  task automatic t_decode;
    logic [11:0] e;
    int          w, c;
    for (int i = 0; i < 13; i++) begin
      e = i < 8 ? 12'h800 >> i : i < 12 ? 12'h001 << (i - 8) : 12'h000;
      w = wr_cnt;
      c = crc_cnt;
      @(posedge mclk) core_rdata <= 8'h90 + 8'(i);
      wr(INS_ADDR_WR, CODES[i]);
      cmp("sel", CODES[i], core_sel);
      cmp("dec", e, core_dec);
      wr(INS_DATA_WR, 8'h40 + 8'(i));
      cmp("wr", i > 1, wr_cnt - w);
      if (i > 1) cmp("wdata", 8'h40 + 8'(i), core_wdata);
      cmp("crc", i == 8, crc_cnt - c);
      if (i == 8) cmp("page", 8'h48, crc_page);
      rd(INS_DATA_RD);
      cmp("rd", i == 0 ? ID : i == 1 ? REV : 8'h90 + 8'(i), rv);
    end
    $display("decode test done");
  endtask : t_decode

  task automatic t_status;
    wr(INS_ADDR_WR, 8'h7f);
    for (int b = 1; b >= 0; b--) begin
      @(posedge mclk) otp_busy <= b[0];
      rd(INS_ADDR_RD);
      cmp("busy", b, rv[BUSY_BIT]);
      cmp("stat", {b[0], STATUS_PAD}, rv);
    end
    $display("status test done");
  endtask : t_status

  task automatic summarize;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize

  initial begin
    rst_n = 0;
    otp_busy = 0;
    core_rdata = 8'h77;
    strap = REV;
    fork
      dbgad_tool_i.idle(4);
      repeat (4) @(posedge mclk);
    join
    @(posedge mclk) rst_n <= 1;
    repeat (10) @(posedge mclk);
    t_reset();
    t_decode();
    t_status();
    summarize();
  end
  // about 40 us of traffic expected
  initial begin
    #200000;
    failures++;
    summarize();
  end
endmodule : dbgad_front_tb

bind dbgad_front dbgad_front_props dbgad_front_props_i (.mclk, .rst_n,
  .debug_clock_line, .debug_data_line_oe, .core_sel, .core_dec, .core_wr,
  .core_wdata, .crc_start, .crc_page);
